// ===== rtl/ble_defs.svh
// Named constants for the Boolean ladder logic engine.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef BLE_DEFS_SVH
`define BLE_DEFS_SVH

// Core clock rate and pass period
`define BLE_CLK_HZ 50000000
`define BLE_PASS_PERIOD_S 1

// Program store: 8 pages x 8 lines x 8 instructions
`define BLE_PROG_WORDS 512
`define BLE_PC_START 9'h000
`define BLE_PC_LAST 9'h1ff
`define BLE_PC_STEP 9'h001

// Instruction word layout
`define BLE_OP_MSB 12
`define BLE_OP_LSB 9
`define BLE_ARG_MSB 8
`define BLE_VAR_MSB 5

// Variable image layout
`define BLE_IN_MSB 31
`define BLE_OUT_LSB 32
`define BLE_VAR_TOP 63
`define BLE_DIAL_IDX 6'h3f

// Sub block save stack
`define BLE_STK_TOP 3

`endif

// ===== rtl/ble_pkg.sv
// Types shared by the Boolean ladder logic engine.
// Assumes nothing of its surroundings.
package ble_pkg;

    typedef enum logic [3:0] {
        BLE_NOP = 4'h0,
        BLE_LOAD = 4'h1,
        BLE_LOAD_NOT = 4'h2,
        BLE_AND = 4'h3,
        BLE_AND_NOT = 4'h4,
        BLE_OR = 4'h5,
        BLE_OR_NOT = 4'h6,
        BLE_AND_BLOCK_COMBINE = 4'h7,
        BLE_OR_BLOCK_COMBINE = 4'h8,
        BLE_OUT = 4'h9,
        BLE_OUT_NOT = 4'ha,
        BLE_RISING_CHANGE_DETECT = 4'hb,
        BLE_SET = 4'hc,
        BLE_RESET = 4'hd,
        BLE_END = 4'he,
        BLE_WARM_RESTART_ENTRY = 4'hf
    } ble_op_t;

    typedef enum logic [1:0] {
        BLE_IDLE = 2'b00,
        BLE_FREEZE = 2'b01,
        BLE_RUN = 2'b10,
        BLE_COMMIT = 2'b11
    } ble_state_t;

endpackage

// ===== rtl/ble_tick_gen.sv
// Free running period counter giving one pulse per pass period.
// Assumes one clock and an asynchronous active high reset.
`timescale 1ns/1ps
`default_nettype none

module ble_tick_gen #(
    parameter int unsigned CYCLES = 50000000
) (
    input wire logic clk, // Core clock
    input wire logic rst, // Asynchronous reset, high
    output logic tick     // One cycle pulse each period
);
    localparam int unsigned CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            tick <= 1'b0;
        end else if (cnt_r == LAST) begin
            cnt_r <= '0;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + CW'(1);
            tick <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ===== rtl/ble_engine.sv
// Cyclic Boolean ladder logic engine: stored program, frozen variable image.
// Assumes program words arrive on the core clock; live inputs and the
// dial clear come from outside the clock domain and are synchronised here.
`timescale 1ns/1ps
`default_nettype none

`include "ble_defs.svh"

// Overview of operation
// - Run whole program once every second
// - Freeze image first, write results after pass
// - Block starts with load, ends with output
// - Sub block builds partial result, combined later
// - Store eight pages, eight lines, eight instructions
// - Load sets result to variable value
// - Inverted load sets result to complement
// - AND and AND NOT update result
// - OR and OR NOT update result
// - AND-block combines partial with saved result
// - OR-block combines partial with saved result
// - OR-blocks nest inside AND-blocks
// - Output writes result or its complement
// - Change detect gives one on rise
// - Set forces variable high when result high
// - Reset forces variable low when result high
// - End stops pass and clears result
// - Next pass starts at the address in end's operand
// - Warm restart marker names pass start
// - Dial flag set by program, host clears
module ble_engine #(
    parameter int unsigned TICK_CYCLES = `BLE_PASS_PERIOD_S * `BLE_CLK_HZ
) (
    input wire logic CORE_CLK,           // Core clock, 50 MHz
    input wire logic SYS_RST,            // Asynchronous reset, high
    input wire logic PRG_WE,             // Program word write strobe
    input wire logic [8:0] PRG_ADDR,     // Program word address
    input wire logic [12:0] PRG_DATA,    // Program word: opcode, operand
    input wire logic [31:0] LIVE_IN,     // Live inputs and module flags
    input wire logic DIAL_CLR,           // Host clears dial request, rising edge
    output logic [31:0] OUT_VARS,        // Committed outputs and flags
    output logic DIAL_REQ,               // Dial request flag to dialer
    output logic PASS_BUSY,              // Pass in progress
    output logic PASS_DONE               // One cycle pulse after commit
);
    logic tick;
    ble_pkg::ble_state_t state_r;
    logic [8:0] pc_r;
    logic [8:0] restart_r;
    logic [12:0] prog_mem [0:`BLE_PROG_WORDS-1];
    logic [`BLE_VAR_TOP:0] img_r;
    logic res_r;
    logic in_block_r;
    logic [`BLE_STK_TOP:0] stk_r;
    logic [`BLE_PROG_WORDS-1:0] hist_r;
    logic [`BLE_PROG_WORDS-1:0] pend_r;
    logic [31:0] in_s1_r;
    logic [31:0] in_s2_r;
    logic clr_s1_r;
    logic clr_s2_r;
    logic clr_d_r;
    logic clr_pend_r;
    logic [12:0] instr;
    ble_pkg::ble_op_t op;
    logic [8:0] arg;
    logic [5:0] var_idx;
    logic var_bit;
    logic running;
    logic clr_pulse;

    ble_tick_gen #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .tick(tick)
    );

    assign instr = prog_mem[pc_r];
    assign op = ble_pkg::ble_op_t'(instr[`BLE_OP_MSB:`BLE_OP_LSB]);
    assign arg = instr[`BLE_ARG_MSB:0];
    assign var_idx = arg[`BLE_VAR_MSB:0];
    assign var_bit = img_r[var_idx];
    assign running = (state_r == ble_pkg::BLE_RUN);
    assign clr_pulse = clr_s2_r & ~clr_d_r;

    // Program store, loaded by the configuration tool
    always_ff @(posedge CORE_CLK) begin
        if (PRG_WE) begin
            prog_mem[PRG_ADDR] <= PRG_DATA;
        end
    end

    // Two stage synchronisers for pins
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            in_s1_r <= 32'h0;
            in_s2_r <= 32'h0;
            clr_s1_r <= 1'b0;
            clr_s2_r <= 1'b0;
            clr_d_r <= 1'b0;
        end else begin
            in_s1_r <= LIVE_IN;
            in_s2_r <= in_s1_r;
            clr_s1_r <= DIAL_CLR;
            clr_s2_r <= clr_s1_r;
            clr_d_r <= clr_s2_r;
        end
    end

    // Host clear is held until the next freeze; a new clear in the
    // consuming cycle stays pending so it is not lost.
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            clr_pend_r <= 1'b0;
        end else if (clr_pulse) begin
            clr_pend_r <= 1'b1;
        end else if (state_r == ble_pkg::BLE_FREEZE) begin
            clr_pend_r <= 1'b0;
        end
    end

    // Pass sequencer; a tick that lands mid pass is dropped
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_r <= ble_pkg::BLE_IDLE;
            pc_r <= `BLE_PC_START;
        end else begin
            unique case (state_r)
                ble_pkg::BLE_IDLE: begin
                    if (tick) begin
                        state_r <= ble_pkg::BLE_FREEZE;
                    end
                end
                ble_pkg::BLE_FREEZE: begin
                    pc_r <= restart_r;
                    state_r <= ble_pkg::BLE_RUN;
                end
                ble_pkg::BLE_RUN: begin
                    // Running off the end of the store closes the pass
                    if (op == ble_pkg::BLE_END || pc_r == `BLE_PC_LAST) begin
                        state_r <= ble_pkg::BLE_COMMIT;
                    end else begin
                        pc_r <= pc_r + `BLE_PC_STEP;
                    end
                end
                ble_pkg::BLE_COMMIT: begin
                    state_r <= ble_pkg::BLE_IDLE;
                end
            endcase
        end
    end

    // Pass start point: reset (power failure) gives the lowest address
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            restart_r <= `BLE_PC_START;
        end else if (running && op == ble_pkg::BLE_END) begin
            restart_r <= arg;
        end else if (running && op == ble_pkg::BLE_WARM_RESTART_ENTRY) begin
            restart_r <= pc_r;
        end
    end

    // Result bit, sub block stack and block tracking
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            res_r <= 1'b0;
            in_block_r <= 1'b0;
            stk_r <= '0;
        end else if (state_r == ble_pkg::BLE_FREEZE) begin
            in_block_r <= 1'b0;
            stk_r <= '0;
        end else if (running) begin
            unique case (op)
                ble_pkg::BLE_LOAD,
                ble_pkg::BLE_LOAD_NOT: begin
                    // Inside a block a load opens a sub block: save result
                    if (in_block_r) begin
                        stk_r <= {stk_r[`BLE_STK_TOP-1:0], res_r};
                    end
                    in_block_r <= 1'b1;
                    if (op == ble_pkg::BLE_LOAD) begin
                        res_r <= var_bit;
                    end else begin
                        res_r <= ~var_bit;
                    end
                end
                ble_pkg::BLE_AND: res_r <= res_r & var_bit;
                ble_pkg::BLE_AND_NOT: res_r <= res_r & ~var_bit;
                ble_pkg::BLE_OR: res_r <= res_r | var_bit;
                ble_pkg::BLE_OR_NOT: res_r <= res_r | ~var_bit;
                ble_pkg::BLE_AND_BLOCK_COMBINE: begin
                    res_r <= res_r & stk_r[0];
                    stk_r <= {1'b0, stk_r[`BLE_STK_TOP:1]};
                end
                ble_pkg::BLE_OR_BLOCK_COMBINE: begin
                    res_r <= res_r | stk_r[0];
                    stk_r <= {1'b0, stk_r[`BLE_STK_TOP:1]};
                end
                ble_pkg::BLE_RISING_CHANGE_DETECT: begin
                    res_r <= res_r & ~hist_r[pc_r];
                end
                ble_pkg::BLE_OUT,
                ble_pkg::BLE_OUT_NOT,
                ble_pkg::BLE_SET,
                ble_pkg::BLE_RESET: begin
                    in_block_r <= 1'b0;
                end
                ble_pkg::BLE_END: begin
                    res_r <= 1'b0;
                    in_block_r <= 1'b0;
                end
                ble_pkg::BLE_NOP,
                ble_pkg::BLE_WARM_RESTART_ENTRY: begin
                end
            endcase
        end
    end

    // Change detect history: input captured now, made visible at pass end
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pend_r <= '0;
            hist_r <= '0;
        end else begin
            if (running && op == ble_pkg::BLE_RISING_CHANGE_DETECT) begin
                pend_r[pc_r] <= res_r;
            end
            if (state_r == ble_pkg::BLE_COMMIT) begin
                hist_r <= pend_r;
            end
        end
    end

    // Variable image: inputs frozen at pass start, program writes in pass
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            img_r <= '0;
        end else if (state_r == ble_pkg::BLE_FREEZE) begin
            img_r[`BLE_IN_MSB:0] <= in_s2_r;
            if (clr_pend_r) begin
                img_r[`BLE_DIAL_IDX] <= 1'b0;
            end
        end else if (running) begin
            unique case (op)
                ble_pkg::BLE_OUT: img_r[arg[`BLE_VAR_MSB:0]] <= res_r;
                ble_pkg::BLE_OUT_NOT: img_r[arg[`BLE_VAR_MSB:0]] <= ~res_r;
                ble_pkg::BLE_SET: begin
                    if (res_r) begin
                        img_r[arg[`BLE_VAR_MSB:0]] <= 1'b1;
                    end
                end
                ble_pkg::BLE_RESET: begin
                    if (res_r) begin
                        img_r[arg[`BLE_VAR_MSB:0]] <= 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Write back only after the pass completes
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            OUT_VARS <= 32'h0;
            DIAL_REQ <= 1'b0;
            PASS_DONE <= 1'b0;
            PASS_BUSY <= 1'b0;
        end else begin
            PASS_DONE <= (state_r == ble_pkg::BLE_COMMIT);
            PASS_BUSY <= (state_r != ble_pkg::BLE_IDLE);
            if (state_r == ble_pkg::BLE_COMMIT) begin
                OUT_VARS <= img_r[`BLE_VAR_TOP:`BLE_OUT_LSB];
                DIAL_REQ <= img_r[`BLE_DIAL_IDX];
            end
        end
    end

    property p_tick_starts;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (state_r == ble_pkg::BLE_IDLE && tick) |=> state_r == ble_pkg::BLE_FREEZE
            ##1 (running && pc_r == $past(restart_r));
    endproperty
    a_tick_starts: assert property (p_tick_starts)
        else $error("pass did not start on tick at restart address");

    property p_outputs_hold;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (state_r != ble_pkg::BLE_COMMIT) |=> $stable(OUT_VARS) && $stable(DIAL_REQ);
    endproperty
    a_outputs_hold: assert property (p_outputs_hold)
        else $error("outputs changed outside write back");

    property p_load;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (running && op == ble_pkg::BLE_LOAD) |=> res_r == $past(var_bit);
    endproperty
    a_load: assert property (p_load)
        else $error("load did not copy variable");

    property p_load_not;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (running && op == ble_pkg::BLE_LOAD_NOT) |=> res_r != $past(var_bit);
    endproperty
    a_load_not: assert property (p_load_not)
        else $error("inverted load did not complement variable");

    property p_and_not;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (running && op == ble_pkg::BLE_AND_NOT && var_bit) |=> !res_r;
    endproperty
    a_and_not: assert property (p_and_not)
        else $error("AND NOT with high variable left result high");

    property p_or;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (running && op == ble_pkg::BLE_OR && var_bit) |=> res_r;
    endproperty
    a_or: assert property (p_or)
        else $error("OR with high variable left result low");

    property p_and_block;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (running && op == ble_pkg::BLE_AND_BLOCK_COMBINE)
            |=> res_r == ($past(res_r) & $past(stk_r[0]));
    endproperty
    a_and_block: assert property (p_and_block)
        else $error("AND block combine wrong");

    property p_or_block;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (running && op == ble_pkg::BLE_OR_BLOCK_COMBINE)
            |=> res_r == ($past(res_r) | $past(stk_r[0]));
    endproperty
    a_or_block: assert property (p_or_block)
        else $error("OR block combine wrong");

    property p_end;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (running && op == ble_pkg::BLE_END)
            |=> !res_r && state_r == ble_pkg::BLE_COMMIT && restart_r == $past(arg)
            ##1 PASS_DONE;
    endproperty
    a_end: assert property (p_end)
        else $error("end did not close pass cleanly");

    property p_set;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (running && op == ble_pkg::BLE_SET && res_r) |=> img_r[$past(var_idx)];
    endproperty
    a_set: assert property (p_set)
        else $error("set did not force variable high");

    property p_reset_var;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (running && op == ble_pkg::BLE_RESET && res_r) |=> !img_r[$past(var_idx)];
    endproperty
    a_reset_var: assert property (p_reset_var)
        else $error("reset did not force variable low");

endmodule

`default_nettype wire

// ===== dv/ble_io_model.sv
// Far side of the ladder engine: input image source and dial-out module.
// Assumes one core clock; the bench supplies the wanted input levels.
`timescale 1ns/1ps
`default_nettype none

module ble_io_model (
    input wire logic clk,            // Core clock
    input wire logic rst,            // Reset, high
    input wire logic [31:0] pattern, // Input levels wanted by the bench
    input wire logic dial_req,       // Dial request flag from the engine
    output logic [31:0] live_in,     // Sensed inputs and module flags
    output logic dial_clr            // Host clear once connected
);
    logic [3:0] call_cnt_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            live_in <= '0;
        end else begin
            live_in <= pattern;
        end
    end

    // Dialer calls while the flag is high; the host clears it after connecting
    // Clear is one short pulse, so a stuck clear cannot mask a later request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            call_cnt_r <= 4'h0;
            dial_clr <= 1'b0;
        end else if (!dial_req) begin
            call_cnt_r <= 4'h0;
            dial_clr <= 1'b0;
        end else if (call_cnt_r != 4'hf) begin
            call_cnt_r <= call_cnt_r + 4'h1;
            dial_clr <= (call_cnt_r >= 4'h8) && (call_cnt_r < 4'he);
        end
    end
endmodule

`default_nettype wire

// ===== dv/boolean_ladder_logic_engine_bench.sv
// Self-checking bench for the ladder logic engine: loads a program, runs passes.
// Assumes the engine, its package and the I/O model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module boolean_ladder_logic_engine_bench;
    localparam int TICKS = 200;
    // Top nibble is the opcode, low nine bits the operand
    localparam logic [15:0] PROG [0:33] = '{
        16'h1009, 16'h902a, 16'ha02b, 16'h1000, 16'h1001, 16'h1002, 16'h3003,
        16'h8000, 16'h7000, 16'h9020, 16'h2000, 16'h4001, 16'h5002, 16'h6003,
        16'ha021, 16'h1000, 16'h3001, 16'h1002, 16'h5003, 16'h8000, 16'h9022,
        16'h1004, 16'hc028, 16'h1005, 16'hd028, 16'h1006, 16'hb000, 16'h9029,
        16'h1007, 16'hb000, 16'hc03f, 16'h1008, 16'h902c, 16'he002};
    logic clk, rst, we, dial_clr, dial_req, busy, done;
    logic [8:0] addr;
    logic [12:0] data;
    logic [31:0] pat, live_in, outv;
    logic [32:0] obs;
    int errors, checks;

    assign obs = {dial_req, outv};

    ble_engine #(.TICK_CYCLES(TICKS)) u_dut (.CORE_CLK(clk), .SYS_RST(rst), .PRG_WE(we),
        .PRG_ADDR(addr), .PRG_DATA(data), .LIVE_IN(live_in), .DIAL_CLR(dial_clr),
        .OUT_VARS(outv), .DIAL_REQ(dial_req), .PASS_BUSY(busy), .PASS_DONE(done));

    ble_io_model u_io (.clk(clk), .rst(rst), .pattern(pat), .dial_req(dial_req),
        .live_in(live_in), .dial_clr(dial_clr));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic finish_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [15:0] w);
        @(posedge clk);
        we <= 1'b1;
        addr <= a;
        data <= {w[15:12], w[8:0]};
        @(posedge clk);
        we <= 1'b0;
    endtask

    task automatic wait_done(output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (done !== 1'b1 && n < 1000);
        if (n >= 1000) begin
            errors++;
            $display("MISMATCH pass_done expected 1 seen 0");
        end
    endtask

    // Inputs change only while idle, well ahead of the next freeze
    task automatic pass(input logic [31:0] p);
        int n;
        @(posedge clk);
        pat <= p;
        wait_done(n);
    endtask

    task automatic seq5(input int bi, input logic [4:0] s, input logic [4:0] e,
                        input int bo, input string nm);
        logic [31:0] p;
        for (int i = 0; i < 5; i++) begin
            p = '0;
            p[bi] = s[i];
            pass(p);
            chk(nm, obs[bo], e[i]);
        end
    endtask

    task automatic t_restart();
        pass(32'h0000_0300);
        chk("init_out", outv[10], 1'b1);
        chk("start_res", outv[11], 1'b0);
        pass(32'h0000_0100);
        chk("init_skip", outv[10], 1'b1);
        chk("end_clear", outv[11], 1'b1);
    endtask

    task automatic t_logic();
        logic a, b, c, d;
        for (int i = 0; i < 16; i++) begin
            {d, c, b, a} = 4'(i);
            pass({28'h0, d, c, b, a});
            chk("and_or_nest", outv[0], a & (b | (c & d)));
            chk("not_forms", outv[1], 1'(~(((~a & ~b) | c) | ~d)));
            chk("or_block", outv[2], (a & b) | c | d);
        end
    endtask

    task automatic t_setrst();
        logic [1:0] s [5] = '{2'b00, 2'b01, 2'b00, 2'b10, 2'b11};
        logic [4:0] e = 5'b00110;
        for (int i = 0; i < 5; i++) begin
            pass({26'h0, s[i], 4'h0});
            chk("set_rst", outv[8], e[i]);
        end
    endtask

    task automatic t_detect();
        seq5(6, 5'b10110, 5'b10010, 9, "rise_det");
    endtask

    task automatic t_dial();
        seq5(7, 5'b01110, 5'b00010, 32, "dial_req");
    endtask

    // Inputs move mid-pass; the pass must still see the frozen image
    task automatic t_freeze();
        int k, m;
        pass(32'h0000_000f);
        k = 0;
        while (busy !== 1'b0 && k < 1000) begin
            @(posedge clk);
            k++;
        end
        while (busy !== 1'b1 && k < 1000) begin
            @(posedge clk);
            k++;
        end
        pat <= 32'h0;
        wait_done(m);
        chk("busy_tail", busy, 1'b1);
        chk("frozen", outv[0], 1'b1);
        chk("period", k + m, TICKS);
        wait_done(m);
        chk("next_image", outv[0], 1'b0);
    endtask

    task automatic t_reset();
        int n;
        pass(32'h0000_0040);
        @(posedge clk);
        rst <= 1'b1;
        pat <= 32'h0000_0240;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("rst_out", outv, 32'h0);
        chk("rst_dial", dial_req, 1'b0);
        wait_done(n);
        chk("hist_clear", outv[9], 1'b1);
        chk("cold_start", outv[10], 1'b1);
    endtask

    // Pass from 0x1fb meets the warm entry at 0x1fd and runs off the top;
    // the pass after must start at the entry, skipping the first output
    task automatic t_top();
        wr(9'h021, 16'he1fb);
        wr(9'h1fb, 16'h100b);
        wr(9'h1fc, 16'h902e);
        wr(9'h1fd, 16'hf000);
        wr(9'h1fe, 16'h100a);
        wr(9'h1ff, 16'h902d);
        pass(32'h0000_0400);
        chk("top_idle", outv[13], 1'b0);
        pass(32'h0000_0c00);
        chk("top_word", outv[13], 1'b1);
        chk("warm_pre", outv[14], 1'b1);
        pass(32'h0);
        chk("warm_entry", outv[14], 1'b1);
        chk("warm_rerun", outv[13], 1'b0);
    endtask

    initial begin
        rst = 1'b1;
        we = 1'b0;
        addr = '0;
        data = '0;
        pat = '0;
        errors = 0;
        checks = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 34; i++) begin
            wr(9'(i), PROG[i]);
        end
        t_restart();
        t_logic();
        t_setrst();
        t_detect();
        t_dial();
        t_freeze();
        t_reset();
        t_top();
        finish_test();
    end

    // Roughly 40 passes are expected; this leaves ample margin
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("MISMATCH watchdog expected done seen timeout");
        finish_test();
    end
endmodule

`default_nettype wire
